//--- rtl/spdc_pkg.sv
// package: constants for the serial port with readback and daisy chain
package spdc_pkg;

  // word geometry
  localparam int          WORD_BITS     = 32;
  localparam int          REG_COUNT     = 16;
  localparam int          SEL_BITS      = 4;

  // register select field in the low bits of every word
  localparam int          SEL_LSB       = 0;
  // readback-address field of register 5
  localparam int          RB_ADDR_MSB   = 31;
  localparam int          RB_ADDR_LSB   = 28;
  localparam logic [3:0]  RB_ADDR_REG   = 4'h5;
  localparam logic [3:0]  RB_ADDR_RST   = 4'h0;
  // daisy-chain enable bit of register 6
  localparam int          DAISY_BIT     = 20;
  localparam logic [3:0]  DAISY_REG     = 4'h6;

  // no-operation word
  localparam logic [31:0] NOP_WORD      = 32'h0000_0000;

  // first and last register touched by the power-up load
  localparam logic [3:0]  LOAD_FIRST    = 4'hF;
  localparam logic [3:0]  LOAD_LAST     = 4'h0;

  // power-up contents, index = register number
  localparam logic [31:0] REG_RST [REG_COUNT] = '{
    32'h0000_0010, 32'h0000_0001, 32'h0000_0002, 32'h0000_0003,
    32'h3800_0004, 32'h0100_0005, 32'h8402_1506, 32'h0000_7007,
    32'h0000_0008, 32'h0000_0009, 32'h0000_000A, 32'h0000_000B,
    32'h0000_000C, 32'h0500_003D, 32'h9000_003E, 32'h8800_280F
  };

  // bit counter saturates here: one full word seen
  localparam logic [5:0]  FULL_COUNT    = 6'h20;

  // controller states
  typedef enum logic [1:0] {
    SPDC_LOAD = 2'b01,
    SPDC_RUN  = 2'b10
  } spdc_state_t;

endpackage

//--- rtl/spdc_regfile.sv
// small register memory: one write port, registered read port
`timescale 1ns/1ps
module spdc_regfile
  import spdc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];  // storage, filled by the power-up load

  // write then registered read; no reset, contents come from the loader
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

//--- rtl/spdc_serial_port.sv
// three-wire serial programming port with readback and daisy chain
`timescale 1ns/1ps
module spdc_serial_port
  import spdc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial pins, all asynchronous to clk
  input  wire logic        serialClk,
  input  wire logic        serialData,
  input  wire logic        load_strobe,
  // serial output toward the host or the next device
  output logic             serial_out_pin,
  // status and write notice to the rest of the chip
  output logic             loadDone,
  output logic             cfgWrPulse,
  output logic [3:0]       cfgWrAddr,
  output logic [31:0]      cfgWrData,
  output logic             daisyMode
);

  // pin synchronisers: stage one feeds only stage two, so a
  // metastable first stage never reaches the decode logic
  logic [1:0] clkSync;            // serial clock
  logic [1:0] dataSync;           // serial data
  logic [1:0] strobeSync;         // load strobe
  // edge history, reset to the idle level of each pin so that
  // leaving reset never looks like an edge
  logic       clkPrev;            // last synced serial clock
  logic       strobePrev;         // last synced strobe

  // frame datapath
  logic [31:0] shiftReg;          // in-shift, preloaded with readback word
  logic [5:0]  bitCount;          // bits taken this frame, saturating
  // steering state and power-up sequencing
  logic [3:0]  rbAddr;            // readback address in effect
  logic [3:0]  loadIdx;           // power-up load pointer
  spdc_state_t state;             // loader / running
  spdc_state_t next_state;        // next loader / running state
  // memory read side
  logic [31:0] rdData;            // readback word from the memory

  // edge decode on synced copies only
  wire clkRise     = clkSync[1] & ~clkPrev;
  wire strobeFall  = ~strobeSync[1] & strobePrev;
  wire strobeRise  = strobeSync[1] & ~strobePrev;

  // frame qualification: nothing is taken until the load is over
  wire running     = (state == SPDC_RUN);
  wire loading     = (state == SPDC_LOAD);
  wire selected    = running & ~strobeSync[1];
  wire shiftEn     = selected & clkRise;
  wire wordFull    = (bitCount == FULL_COUNT);
  wire isNop       = (shiftReg == NOP_WORD);

  // commit only a whole, non-nop word on the strobe rising edge;
  // a short frame is dropped rather than half applied
  wire commit      = running & strobeRise & wordFull & ~isNop;
  wire [3:0] selCode = shiftReg[SEL_LSB +: SEL_BITS];

  // memory write port: loader first, then host commits
  wire memWrEn     = loading | commit;
  wire [3:0]  memWrAddr = loading ? loadIdx : selCode;
  wire [31:0] memWrData = loading ? REG_RST[loadIdx] : shiftReg;
  wire loadEnd     = loading & (loadIdx == LOAD_LAST);

  // non-chained part stops driving data after one word; a chained
  // part keeps passing bits on for the devices behind it
  wire nextOut     = (daisyMode | ~wordFull) ? shiftReg[31] : 1'b0;

  // loader/run state change; the loader runs once after reset and
  // RUN is kept until the next reset, a stray code reloads
  always_comb begin
    next_state = state;
    unique case (state)
      SPDC_LOAD: if (loadEnd) next_state = SPDC_RUN;
      SPDC_RUN:  next_state = SPDC_RUN;
      default:   next_state = SPDC_LOAD;
    endcase
  end

  // register memory: written by the loader or a commit, read at the
  // readback address; the read is registered, so it trails by a cycle
  spdc_regfile #(
    .WIDTH (WORD_BITS),
    .DEPTH (REG_COUNT),
    .AW    (SEL_BITS)
  ) spdc_regfile_inst (
    .clk    (clk),
    .wrEn   (memWrEn),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (rbAddr),
    .rdData (rdData)
  );

  // two-flop synchronisers and edge history; the two flops cost a
  // few cycles of latency, which the long serial half periods absorb
  // without losing a bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync    <= 2'b00;
      dataSync   <= 2'b00;
      strobeSync <= 2'b11;
      clkPrev    <= 1'b0;
      strobePrev <= 1'b1;
    end else begin
      // shift each pin one stage further
      clkSync    <= {clkSync[0], serialClk};
      dataSync   <= {dataSync[0], serialData};
      strobeSync <= {strobeSync[0], load_strobe};
      clkPrev    <= clkSync[1];
      strobePrev <= strobeSync[1];
    end
  end

  // power-up load walks from the top register down, one register a
  // cycle; a frame that starts before it ends gets no readback preload, yet its bits after the load are still taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= SPDC_LOAD;
      loadIdx <= LOAD_FIRST;
    end else begin
      state <= next_state;
      // count down until register zero has been written
      if (loading && !loadEnd) begin
        loadIdx <= loadIdx - 4'h1;
      end
    end
  end

  // shift register: preload readback word at frame start, then
  // shift msb first; old bits fall out the top toward the next part
  // a frame that ends early leaves the counter short, and that
  // alone blocks the commit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= 32'h0000_0000;
      bitCount <= 6'h00;
    end else if (running && strobeFall) begin
      // frame start: load the word to be read back
      shiftReg <= rdData;
      bitCount <= 6'h00;
    end else if (shiftEn) begin
      // one bit per detected serial clock rise
      shiftReg <= {shiftReg[30:0], dataSync[1]};
      if (!wordFull) begin
        bitCount <= bitCount + 6'h01;
      end
    end
  end

  // serial output follows the top bit; chained parts pass everything
  // held low outside a frame rather than released, since the pin
  // has no enable of its own
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_pin <= 1'b0;
    end else begin
      // drive data only while selected
      serial_out_pin <= selected ? nextOut : 1'b0;
    end
  end

  // shadow copies of the fields that steer this port; the readback
  // address changes only at the power-up load or at commit, so a frame uses the older one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rbAddr    <= RB_ADDR_RST;
      daisyMode <= 1'b0;
    end else if (loading) begin
      // power-up table values
      if (loadIdx == RB_ADDR_REG) begin
        rbAddr <= REG_RST[RB_ADDR_REG][RB_ADDR_MSB:RB_ADDR_LSB];
      end
      if (loadIdx == DAISY_REG) begin
        daisyMode <= REG_RST[DAISY_REG][DAISY_BIT];
      end
    end else if (commit) begin
      // host commit of the readback or chaining register
      if (selCode == RB_ADDR_REG) begin
        rbAddr <= shiftReg[RB_ADDR_MSB:RB_ADDR_LSB];
      end
      if (selCode == DAISY_REG) begin
        daisyMode <= shiftReg[DAISY_BIT];
      end
    end
  end

  // write notice to the rest of the chip, one cycle per commit
  // the notice appears on the same edge as the memory write; loadDone rises
  // one cycle after the last power-up write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgWrPulse <= 1'b0;
      cfgWrAddr  <= 4'h0;
      cfgWrData  <= 32'h0000_0000;
      loadDone   <= 1'b0;
    end else begin
      // loader writes and host commits both report here
      cfgWrPulse <= memWrEn;
      cfgWrAddr  <= memWrAddr;
      cfgWrData  <= memWrData;
      loadDone   <= running;
    end
  end

endmodule

//--- verification/spdc_host.sv
// host model: drives serial clock, data and load strobe
`timescale 1ns/1ps
module spdc_host (
  input  logic clk,
  input  logic serial_out_pin,
  output logic serialClk,
  output logic serialData,
  output logic load_strobe
);
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    load_strobe = 1'b1;
  end
  // n bits msb first; half serial period is 16 clocks
  task automatic xfer(input logic [63:0] w, input int n,
                      output logic [63:0] rb);
    rb = '0;
    @(negedge clk) load_strobe = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialData = w[i];
      repeat (16) @(negedge clk);
      rb = {rb[62:0], serial_out_pin};
      serialClk = 1'b1;
      repeat (16) @(negedge clk);
      serialClk = 1'b0;
    end
    repeat (16) @(negedge clk);
    load_strobe = 1'b1;
    serialData = ~serialData; // released line shows no stale level
  endtask
endmodule

//--- verification/spdc_serial_port_props.sv
// checker: port properties of the serial port
`timescale 1ns/1ps
module spdc_serial_port_props (
  input logic        clk,
  input logic        rst_n,
  input logic        load_strobe,
  input logic        serial_out_pin,
  input logic        loadDone,
  input logic        cfgWrPulse,
  input logic [3:0]  cfgWrAddr,
  input logic [31:0] cfgWrData,
  input logic        daisyMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_LOAD_FIRST:
    assert property ($rose(cfgWrPulse) && !loadDone |-> cfgWrAddr == 4'hF)
    else $error("load start");
  AST_LOAD_DOWN:
    assert property (cfgWrPulse && !loadDone && cfgWrAddr != 4'h0 |=>
      cfgWrPulse && cfgWrAddr == $past(cfgWrAddr) - 4'h1) else $error("order");
  AST_SEL:
    assert property (cfgWrPulse |-> cfgWrAddr == cfgWrData[3:0])
    else $error("select");
  AST_NOP:
    assert property (cfgWrPulse |-> cfgWrData != 32'h0) else $error("nop");
  AST_COMMIT:
    assert property (cfgWrPulse && loadDone |-> $past(load_strobe))
    else $error("commit");
  AST_ONE:
    assert property (cfgWrPulse && loadDone |=> !cfgWrPulse) else $error("one");
  AST_DAISY:
    assert property (cfgWrPulse && cfgWrAddr == 4'h6 |->
      daisyMode == cfgWrData[20]) else $error("daisy");
  AST_IDLE:
    assert property (load_strobe [*6] |-> !serial_out_pin) else $error("idle");
  cover property (cfgWrPulse && loadDone);
  cover property (daisyMode);
  cover property ($rose(loadDone));
  cover property (cfgWrPulse && loadDone && cfgWrAddr == 4'h5);
endmodule
bind spdc_serial_port spdc_serial_port_props spdc_serial_port_props_inst (
  .clk, .rst_n, .load_strobe, .serial_out_pin, .loadDone, .cfgWrPulse,
  .cfgWrAddr, .cfgWrData, .daisyMode);

//--- verification/tb_spdc_serial_port.sv
// testbench: power-up load, readback, nop, daisy chain
`timescale 1ns/1ps
module tb_spdc_serial_port
  import spdc_pkg::*;
;
  typedef struct packed {logic [31:0] w; logic [31:0] rb; logic wr;} spdc_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        serialClk, serialData, load_strobe, serial_out_pin;
  logic        loadDone, cfgWrPulse, daisyMode;
  logic [3:0]  cfgWrAddr;
  logic [31:0] cfgWrData;
  logic [63:0] rb;
  logic [35:0] wq [$];
  int          fails = 0;
  int          n_checks = 0;
  spdc_row_t   rows [6] = '{
    {32'h3100_0005, 32'h0000_0010, 1'b1},
    {32'h0000_ABC3, 32'h0000_0003, 1'b1},
    {32'h0000_0000, 32'h0000_ABC3, 1'b0},
    {32'hD100_0005, 32'h0000_ABC3, 1'b1},
    {32'h0500_003D, 32'h0500_003D, 1'b1},
    {32'h8412_1506, 32'h0500_003D, 1'b1}};
  spdc_serial_port spdc_serial_port_inst (.clk, .rst_n, .serialClk,
    .serialData, .load_strobe, .serial_out_pin, .loadDone, .cfgWrPulse,
    .cfgWrAddr, .cfgWrData, .daisyMode);
  spdc_host spdc_host_inst (.clk, .serial_out_pin, .serialClk, .serialData,
    .load_strobe);
  always #2.5 clk = ~clk;
  // log every register write, on the edge where the pulse has settled
  always @(negedge clk)
    if (cfgWrPulse === 1'b1)
      wq.push_back({cfgWrAddr, cfgWrData});
  task automatic chk(input string s, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // strobe gap covers the commit latency
  task automatic post(input logic ex, input logic [35:0] e);
    repeat (12) @(negedge clk);
    chk("writes", ex, wq.size());
    if (ex && wq.size() > 0)
      chk("write", e, wq.pop_front());
    wq = {};
  endtask
  // wait for the power-up load, then check its order and contents
  task automatic powerup;
    for (int i = 0; i < 200 && loadDone !== 1'b1; i++)
      @(negedge clk);
    if (loadDone !== 1'b1) begin
      fails++;
      final_report();
    end
    repeat (4) @(negedge clk);
    chk("load count", 16, wq.size());
    for (int i = 15; i >= 0 && wq.size() > 0; i--)
      chk("load", {i[3:0], REG_RST[i]}, wq.pop_front());
    wq = {};
  endtask
  initial begin
    repeat (2) @(negedge clk);
    chk("reset", 4'h0, {serial_out_pin, loadDone, cfgWrPulse, daisyMode});
    @(negedge clk) rst_n = 1'b1;
    powerup();
    $display("test powerup done");
    foreach (rows[k]) begin
      spdc_host_inst.xfer({32'h0, rows[k].w}, 32, rb);
      chk("readback", rows[k].rb, rb[31:0]);
      post(rows[k].wr, {rows[k].w[3:0], rows[k].w});
    end
    $display("test rows done");
    chk("daisy on", 1'b1, daisyMode);
    spdc_host_inst.xfer({32'h0000_1234, 32'h5600_0007}, 64, rb);
    chk("own word", 32'h0500_003D, rb[63:32]);
    chk("passed on", 32'h0000_1234, rb[31:0]);
    post(1'b1, {4'h7, 32'h5600_0007});
    // nop for this part, a word for the part behind it
    spdc_host_inst.xfer({32'h0000_5678, NOP_WORD}, 64, rb);
    chk("nop own", 32'h0500_003D, rb[63:32]);
    chk("nop passed", 32'h0000_5678, rb[31:0]);
    post(1'b0, 36'h0);
    $display("test daisy done");
    spdc_host_inst.xfer(64'hFFFF, 16, rb);
    post(1'b0, 36'h0);
    $display("test short done");
    // reset in mid-run: outputs clear, load repeats, chaining off again
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("mid reset", 4'h0, {serial_out_pin, loadDone, cfgWrPulse, daisyMode});
    wq = {};
    @(negedge clk) rst_n = 1'b1;
    powerup();
    chk("daisy off", REG_RST[6][20], daisyMode);
    // plain part: own word, then a low line once the word is out
    spdc_host_inst.xfer({32'h0000_1234, NOP_WORD}, 64, rb);
    chk("plain word", REG_RST[REG_RST[5][31:28]], rb[63:32]);
    chk("plain tail", 32'h0, rb[31:0]);
    post(1'b0, 36'h0);
    $display("test reset done");
    final_report();
  end
endmodule
